/* File: src/ifm_monitor.sv */
// Transmit and receive interface fault monitor with AXI4-Lite registers.
// Assumes buffer and frame strobes come from logic on core_clk; other pins are async.
//
// The AXI4-Lite slave port and the address map were chosen for this implementation.
`timescale 1ns/10ps
module ifm_monitor #(
    parameter int FBER_WINDOW = ifm_pkg::FBER_WINDOW_BITS,
    parameter int FBER_LIMIT = ifm_pkg::FBER_ERR_LIMIT
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // AXI4-Lite write
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Transmit side pins
    input wire logic tx_data,
    input wire logic tx_clk,
    input wire logic tx_pll_lock,
    input wire logic drop_pll_lock,
    input wire logic tx_cfg_unable,
    // Receive side pins
    input wire logic rx_data,
    input wire logic rx_clk,
    input wire logic buf_pll_lock,
    input wire logic demux_lock,
    // Receive buffer and framer, core clock domain
    input wire logic rx_buf_rd,
    input wire logic rx_buf_empty,
    input wire logic rx_buf_wr,
    input wire logic rx_buf_full,
    input wire logic frame_bit_valid,
    input wire logic frame_bit_err,
    // Indications
    output logic [14:0] fault_status,
    output logic tx_data_stuck_indication,
    output logic rx_data_stuck_indication,
    output logic frame_error_rate_fault,
    output logic rx_clock_inactive_fault,
    output logic tx_use_internal_clk,
    output logic rx_use_satellite_clk,
    output logic switchover_req,
    output logic alarm_active
);
    // ************
    // Register state
    // ************
    logic [31:0] ctrl, next_ctrl;
    logic [15:0] data_limit, next_data_limit;
    logic [15:0] clk_limit, next_clk_limit;
    logic aw_held, next_aw_held, w_held, next_w_held;
    logic [3:0] aw_addr, next_aw_addr;
    logic [31:0] w_data, next_w_data;
    logic [3:0] w_strb, next_w_strb;
    logic bvalid, next_bvalid;
    logic [1:0] bresp, next_bresp;
    logic rvalid, next_rvalid;
    logic [1:0] rresp, next_rresp;
    logic [31:0] rdata, next_rdata;
    logic [14:0] status, next_status;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[8*b +: 8] = nw[8*b +: 8];
            end
        end
        return r;
    endfunction

    // ************
    // AXI4-Lite slave
    // ************
    logic do_write;
    assign s_axi_awready = !aw_held;
    assign s_axi_wready = !w_held;
    assign s_axi_arready = !rvalid;
    assign do_write = aw_held && w_held && !bvalid;

    always_comb begin
        next_aw_held = aw_held;
        next_aw_addr = aw_addr;
        next_w_held = w_held;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_bvalid = bvalid;
        next_bresp = bresp;
        next_ctrl = ctrl;
        next_data_limit = data_limit;
        next_clk_limit = clk_limit;
        if (s_axi_awvalid && !aw_held) begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_held) begin
            next_w_held = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        if (bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        if (do_write) begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = ifm_pkg::RESP_OKAY;
            case (aw_addr)
                ifm_pkg::ADDR_CTRL: begin
                    next_ctrl = merge(ctrl, w_data, w_strb) & 32'h0000_001F;
                end
                ifm_pkg::ADDR_DATA_LIMIT: begin
                    next_data_limit = 16'(merge({16'h0000, data_limit}, w_data, w_strb));
                end
                ifm_pkg::ADDR_CLK_LIMIT: begin
                    next_clk_limit = 16'(merge({16'h0000, clk_limit}, w_data, w_strb));
                end
                ifm_pkg::ADDR_STATUS: begin
                    next_bresp = ifm_pkg::RESP_OKAY;
                end
                default: begin
                    next_bresp = ifm_pkg::RESP_SLVERR;
                end
            endcase
        end
    end

    always_comb begin
        next_rvalid = rvalid;
        next_rdata = rdata;
        next_rresp = rresp;
        if (rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end
        if (s_axi_arvalid && !rvalid) begin
            next_rvalid = 1'b1;
            next_rresp = ifm_pkg::RESP_OKAY;
            case (s_axi_araddr)
                ifm_pkg::ADDR_CTRL: next_rdata = ctrl;
                ifm_pkg::ADDR_STATUS: next_rdata = {17'h00000, status};
                ifm_pkg::ADDR_DATA_LIMIT: next_rdata = {16'h0000, data_limit};
                ifm_pkg::ADDR_CLK_LIMIT: next_rdata = {16'h0000, clk_limit};
                default: begin
                    next_rdata = 32'h0000_0000;
                    next_rresp = ifm_pkg::RESP_SLVERR;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl <= ifm_pkg::CTRL_RESET;
            data_limit <= ifm_pkg::DATA_STUCK_CYC;
            clk_limit <= ifm_pkg::CLK_QUIET_CYC;
            aw_held <= 1'b0;
            aw_addr <= 4'h0;
            w_held <= 1'b0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            bvalid <= 1'b0;
            bresp <= 2'h0;
            rvalid <= 1'b0;
            rresp <= 2'h0;
            rdata <= 32'h0000_0000;
        end else begin
            ctrl <= next_ctrl;
            data_limit <= next_data_limit;
            clk_limit <= next_clk_limit;
            aw_held <= next_aw_held;
            aw_addr <= next_aw_addr;
            w_held <= next_w_held;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            bvalid <= next_bvalid;
            bresp <= next_bresp;
            rvalid <= next_rvalid;
            rresp <= next_rresp;
            rdata <= next_rdata;
        end
    end

    assign s_axi_bvalid = bvalid;
    assign s_axi_bresp = bresp;
    assign s_axi_rvalid = rvalid;
    assign s_axi_rresp = rresp;
    assign s_axi_rdata = rdata;

    // ************
    // Activity detectors
    // ************
    ifm_act_if act [ifm_pkg::N_CH] ();
    assign act[ifm_pkg::CH_TX_DATA].raw = tx_data;
    assign act[ifm_pkg::CH_TX_CLK].raw = tx_clk;
    assign act[ifm_pkg::CH_RX_DATA].raw = rx_data;
    assign act[ifm_pkg::CH_RX_CLK].raw = rx_clk;
    assign act[ifm_pkg::CH_TX_DATA].limit = data_limit;
    assign act[ifm_pkg::CH_TX_CLK].limit = clk_limit;
    assign act[ifm_pkg::CH_RX_DATA].limit = data_limit;
    assign act[ifm_pkg::CH_RX_CLK].limit = clk_limit;

    for (genvar i = 0; i < ifm_pkg::N_CH; i++) begin : g_det
        ifm_activity_det u_det (
            .core_clk(core_clk),
            .rst_n(rst_n),
            .port(act[i].det)
        );
    end

    // ************
    // Lock and configuration pin synchronisers
    // ************
    logic [4:0] pin_s1, pin_s2;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1 <= 5'h00;
            pin_s2 <= 5'h00;
        end else begin
            pin_s1 <= {tx_cfg_unable, demux_lock, buf_pll_lock, drop_pll_lock, tx_pll_lock};
            pin_s2 <= pin_s1;
        end
    end

    // ************
    // Frame error rate window
    // ************
    localparam int BW = $clog2(FBER_WINDOW + 1);
    logic [BW-1:0] bit_cnt, next_bit_cnt;
    logic [BW-1:0] err_cnt, next_err_cnt;
    logic fber, next_fber;
    // Errors counted per window; verdict holds until the next window ends
    always_comb begin
        next_bit_cnt = bit_cnt;
        next_err_cnt = err_cnt;
        next_fber = fber;
        if (frame_bit_valid) begin
            if (bit_cnt == BW'(FBER_WINDOW - 1)) begin
                next_bit_cnt = '0;
                next_err_cnt = '0;
                next_fber = (err_cnt + BW'(frame_bit_err)) > BW'(FBER_LIMIT); // RULE_14
            end else begin
                next_bit_cnt = bit_cnt + BW'(1);
                next_err_cnt = err_cnt + BW'(frame_bit_err);
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            bit_cnt <= '0;
            err_cnt <= '0;
            fber <= 1'b0;
        end else begin
            bit_cnt <= next_bit_cnt;
            err_cnt <= next_err_cnt;
            fber <= next_fber;
        end
    end

    // ************
    // Fault and alarm status
    // ************
    ifm_pkg::ifm_chk_mode_t tx_mode, rx_mode;
    assign tx_mode = ifm_pkg::ifm_chk_mode_t'(ctrl[ifm_pkg::CTRL_TX_MODE_LSB +: 2]);
    assign rx_mode = ifm_pkg::ifm_chk_mode_t'(ctrl[ifm_pkg::CTRL_RX_MODE_LSB +: 2]);

    // Mode none and the invalid code both suppress data checks
    always_comb begin
        next_status = '0;
        next_status[ifm_pkg::ST_TX_DATA] = (tx_mode == ifm_pkg::IFM_CHK_DATA)
            && act[ifm_pkg::CH_TX_DATA].stuck; // RULE_01 RULE_03
        next_status[ifm_pkg::ST_TX_AIS] = (tx_mode == ifm_pkg::IFM_CHK_AIS)
            && act[ifm_pkg::CH_TX_DATA].stuck && act[ifm_pkg::CH_TX_DATA].level; // RULE_02
        next_status[ifm_pkg::ST_TX_CLK] = act[ifm_pkg::CH_TX_CLK].stuck; // RULE_05
        next_status[ifm_pkg::ST_TX_PLL] = !pin_s2[0]; // RULE_06
        next_status[ifm_pkg::ST_DROP] = ctrl[ifm_pkg::CTRL_DROP_INSERT] && !pin_s2[1]; // RULE_07
        next_status[ifm_pkg::ST_TX_PROG] = (tx_mode == ifm_pkg::IFM_CHK_BAD); // RULE_08
        next_status[ifm_pkg::ST_TX_CFG] = pin_s2[4]; // RULE_09
        next_status[ifm_pkg::ST_UNDERFLOW] = rx_buf_rd && rx_buf_empty; // RULE_10
        next_status[ifm_pkg::ST_OVERFLOW] = rx_buf_wr && rx_buf_full; // RULE_11
        next_status[ifm_pkg::ST_RX_DATA] = (rx_mode == ifm_pkg::IFM_CHK_DATA)
            && act[ifm_pkg::CH_RX_DATA].stuck; // RULE_12
        next_status[ifm_pkg::ST_RX_AIS] = (rx_mode == ifm_pkg::IFM_CHK_AIS)
            && act[ifm_pkg::CH_RX_DATA].stuck && act[ifm_pkg::CH_RX_DATA].level; // RULE_13
        next_status[ifm_pkg::ST_FBER] = fber; // RULE_14
        next_status[ifm_pkg::ST_BUF_PLL] = !pin_s2[2]; // RULE_15
        next_status[ifm_pkg::ST_RX_CLK] = act[ifm_pkg::CH_RX_CLK].stuck; // RULE_16
        next_status[ifm_pkg::ST_DEMUX] = !pin_s2[3]; // RULE_17
    end

    // Live levels, re-evaluated every cycle
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            status <= '0;
        end else begin
            status <= next_status; // RULE_20
        end
    end

    assign fault_status = status;
    assign tx_data_stuck_indication = status[ifm_pkg::ST_TX_DATA] | status[ifm_pkg::ST_TX_AIS];
    assign rx_data_stuck_indication = status[ifm_pkg::ST_RX_DATA] | status[ifm_pkg::ST_RX_AIS];
    assign frame_error_rate_fault = status[ifm_pkg::ST_FBER];
    assign rx_clock_inactive_fault = status[ifm_pkg::ST_RX_CLK];
    assign tx_use_internal_clk = status[ifm_pkg::ST_TX_CLK]; // RULE_05
    assign rx_use_satellite_clk = status[ifm_pkg::ST_RX_CLK]; // RULE_16
    // Alarms such as all-ones never reach the switchover request
    assign switchover_req = |(status & ifm_pkg::FAULT_MASK); // RULE_04 RULE_18
    assign alarm_active = |(status & ifm_pkg::ALARM_MASK); // RULE_18
endmodule

/* File: src/ifm_pkg.sv */
// Constants, field layouts and register map of the interface fault monitor.
// Assumes a single 125 MHz core clock and AXI4-Lite software access.
// Notes on behaviour
// RULE_01 - Data mode: stuck ones or zeros faults
// RULE_02 - Alarm mode: only stuck ones raises alarm
// RULE_03 - Mode none: transmit data indication never set
// RULE_04 - All-ones is alarm, data-stable is fault
// RULE_05 - No transmit clock: alarm, use internal clock
// RULE_06 - Transmit PLL unlocked raises fault
// RULE_07 - Drop PLL unlock faults only in drop-insert
// RULE_08 - Invalid transmit setting raises programming fault
// RULE_09 - Unexecutable transmit configuration raises configuration fault
// RULE_10 - Read of empty buffer raises underflow alarm
// RULE_11 - Write of full buffer raises overflow alarm
// RULE_12 - Receive data mode: stuck data faults
// RULE_13 - Receive alarm mode ones only; none never
// RULE_14 - Frame error rate above 1e-3 faults
// RULE_15 - Buffer clock PLL unlocked raises fault
// RULE_16 - No receive clock: fault, use satellite clock
// RULE_17 - Demultiplexer not locked raises fault
// RULE_18 - Faults request switchover, alarms never do
// RULE_19 - Stuck after count of quiet cycles, clears on edge
// RULE_20 - Status bits are live levels, never latched
package ifm_pkg;
    // ************
    // Timing
    // ************
    localparam int CLK_MHZ = 125;
    localparam int DATA_STUCK_TIME_US = 10;
    localparam int CLK_QUIET_TIME_US = 1;
    localparam logic [15:0] DATA_STUCK_CYC = 16'(DATA_STUCK_TIME_US * CLK_MHZ);
    localparam logic [15:0] CLK_QUIET_CYC = 16'(CLK_QUIET_TIME_US * CLK_MHZ);
    localparam int FBER_WINDOW_BITS = 10000;
    localparam int FBER_ERR_LIMIT = 10;

    // ************
    // Register map
    // ************
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h4;
    localparam logic [3:0] ADDR_DATA_LIMIT = 4'h8;
    localparam logic [3:0] ADDR_CLK_LIMIT = 4'hC;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ************
    // Control fields
    // ************
    localparam int CTRL_TX_MODE_LSB = 0;
    localparam int CTRL_RX_MODE_LSB = 2;
    localparam int CTRL_DROP_INSERT = 4;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

    typedef enum logic [1:0] {
        IFM_CHK_NONE = 2'h0,
        IFM_CHK_DATA = 2'h1,
        IFM_CHK_AIS = 2'h2,
        IFM_CHK_BAD = 2'h3
    } ifm_chk_mode_t;

    // ************
    // Status fields
    // ************
    localparam int ST_TX_DATA = 0;
    localparam int ST_TX_AIS = 1;
    localparam int ST_TX_CLK = 2;
    localparam int ST_TX_PLL = 3;
    localparam int ST_DROP = 4;
    localparam int ST_TX_PROG = 5;
    localparam int ST_TX_CFG = 6;
    localparam int ST_UNDERFLOW = 7;
    localparam int ST_OVERFLOW = 8;
    localparam int ST_RX_DATA = 9;
    localparam int ST_RX_AIS = 10;
    localparam int ST_FBER = 11;
    localparam int ST_BUF_PLL = 12;
    localparam int ST_RX_CLK = 13;
    localparam int ST_DEMUX = 14;
    localparam int ST_W = 15;
    // Which status bits are faults; the rest are alarms
    localparam logic [14:0] FAULT_MASK = 15'h7A79;
    localparam logic [14:0] ALARM_MASK = 15'h0586;

    // ************
    // Activity channels
    // ************
    localparam int CH_TX_DATA = 0;
    localparam int CH_TX_CLK = 1;
    localparam int CH_RX_DATA = 2;
    localparam int CH_RX_CLK = 3;
    localparam int N_CH = 4;
endpackage

/* File: src/ifm_act_if.sv */
// Carrier between the monitor and one activity detector.
// Assumes raw is an asynchronous pin level.
`timescale 1ns/10ps
interface ifm_act_if;
    logic raw;
    logic [15:0] limit;
    logic stuck;
    logic level;
    modport det (input raw, input limit, output stuck, output level);
    modport mon (output raw, output limit, input stuck, input level);
endinterface

/* File: src/ifm_activity_det.sv */
// Activity detector: synchronises a pin and flags it stuck when quiet.
// Assumes limit is stable and non-zero while in use.
`timescale 1ns/10ps
module ifm_activity_det (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Channel
    ifm_act_if.det port
);
    logic sync1, sync2, prev;
    logic [15:0] quiet, next_quiet;
    logic stuck, next_stuck;

    always_comb begin
        next_quiet = quiet;
        next_stuck = stuck;
        if (sync2 != prev) begin
            next_quiet = 16'h0000;
            next_stuck = 1'b0; // RULE_19
        end else if (quiet >= port.limit) begin
            next_stuck = 1'b1; // RULE_19
        end else begin
            next_quiet = quiet + 16'h0001;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1 <= 1'b0;
            sync2 <= 1'b0;
            prev <= 1'b0;
            quiet <= 16'h0000;
            stuck <= 1'b0;
        end else begin
            sync1 <= port.raw;
            sync2 <= sync1;
            prev <= sync2;
            quiet <= next_quiet;
            stuck <= next_stuck;
        end
    end

    assign port.stuck = stuck;
    assign port.level = prev;
endmodule

/* File: tb/ifm_monitor_asserts.sv */
// Checker of the fault monitor status and indication ports.
// Assumes it is bound to ifm_monitor and sees only its ports.
`timescale 1ns/10ps
module ifm_monitor_chk (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Watched inputs
    input wire logic tx_pll_lock,
    input wire logic buf_pll_lock,
    input wire logic demux_lock,
    input wire logic rx_buf_rd,
    input wire logic rx_buf_empty,
    input wire logic rx_buf_wr,
    input wire logic rx_buf_full,
    // Indications
    input wire logic [14:0] fault_status,
    input wire logic tx_use_internal_clk,
    input wire logic rx_use_satellite_clk,
    input wire logic switchover_req,
    input wire logic alarm_active
);
    // ************
    // Properties
    // ************
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    property p_switch;
        switchover_req == |(fault_status & ifm_pkg::FAULT_MASK);
    endproperty
    a_switch: assert property (p_switch) else $error("switchover mismatch");
    property p_alarm;
        alarm_active == |(fault_status & ifm_pkg::ALARM_MASK);
    endproperty
    a_alarm: assert property (p_alarm) else $error("alarm summary mismatch");
    // Only the unlock direction: sync flops restart unlocked after reset
    property p_tx_pll;
        !tx_pll_lock [*3] |=> fault_status[ifm_pkg::ST_TX_PLL];
    endproperty
    a_tx_pll: assert property (p_tx_pll) else $error("tx pll fault missing");
    property p_buf_pll;
        !buf_pll_lock [*3] |=> fault_status[ifm_pkg::ST_BUF_PLL];
    endproperty
    a_buf_pll: assert property (p_buf_pll) else $error("buffer pll fault missing");
    property p_demux;
        !demux_lock [*3] |=> fault_status[ifm_pkg::ST_DEMUX];
    endproperty
    a_demux: assert property (p_demux) else $error("demux fault missing");
    property p_under;
        1'b1 |=> fault_status[ifm_pkg::ST_UNDERFLOW] == $past(rx_buf_rd && rx_buf_empty);
    endproperty
    a_under: assert property (p_under) else $error("underflow mismatch");
    property p_over;
        1'b1 |=> fault_status[ifm_pkg::ST_OVERFLOW] == $past(rx_buf_wr && rx_buf_full);
    endproperty
    a_over: assert property (p_over) else $error("overflow mismatch");
    property p_tx_sel;
        tx_use_internal_clk == fault_status[ifm_pkg::ST_TX_CLK];
    endproperty
    a_tx_sel: assert property (p_tx_sel) else $error("tx clock select mismatch");
    property p_rx_sel;
        rx_use_satellite_clk == fault_status[ifm_pkg::ST_RX_CLK];
    endproperty
    a_rx_sel: assert property (p_rx_sel) else $error("rx clock select mismatch");
endmodule

bind ifm_monitor ifm_monitor_chk ifm_monitor_chk_inst (.*);

/* File: tb/ifm_partner.sv */
// Model of the customer equipment and satellite path line pins.
// Assumes the bench picks which lines fall quiet and at what level.
`timescale 1ns/10ps
module ifm_partner (
    // Control from bench
    input wire logic [3:0] quiet,
    input wire logic [3:0] lvl,
    // Pins: tx_data, tx_clk, rx_data, rx_clk
    output logic [3:0] pins
);
    logic ph = 1'b0;
    // Own clock of 24 ns period, every edge landing on a core clock edge
    always #12 ph = ~ph;
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            pins[i] = quiet[i] ? lvl[i] : (ph ^ i[0]);
        end
    end
endmodule

/* File: tb/interface_fault_monitor_bench.sv */
// Self-checking bench of the interface fault monitor.
// Assumes the partner drives the line pins and the bench all else.
`timescale 1ns/10ps
module interface_fault_monitor_bench;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic frame_bit_valid = 1'b0, frame_bit_err = 1'b0;
    logic [8:0] cv = 9'h0;
    logic [3:0] quiet = 4'h0, lvl = 4'h0, pins;
    logic tx_data, tx_clk, rx_data, rx_clk, tx_pll_lock, drop_pll_lock, tx_cfg_unable;
    logic buf_pll_lock, demux_lock, rx_buf_rd, rx_buf_empty, rx_buf_wr, rx_buf_full;
    logic [14:0] fault_status;
    logic tx_data_stuck_indication, rx_data_stuck_indication, frame_error_rate_fault;
    logic rx_clock_inactive_fault, tx_use_internal_clk, rx_use_satellite_clk;
    logic switchover_req, alarm_active;
    int err_count = 0, cmp_count = 0, cyc = 0;
    int idx [9] = '{ifm_pkg::ST_TX_PLL, ifm_pkg::ST_BUF_PLL, ifm_pkg::ST_DEMUX, -1,
        ifm_pkg::ST_TX_CFG, ifm_pkg::ST_UNDERFLOW, ifm_pkg::ST_OVERFLOW, -1, -1};

    assign {rx_clk, rx_data, tx_clk, tx_data} = pins;
    assign {drop_pll_lock, demux_lock, buf_pll_lock, tx_pll_lock} = ~cv[3:0];
    assign tx_cfg_unable = cv[4];
    assign rx_buf_rd = cv[5] | cv[7];
    assign rx_buf_empty = cv[5];
    assign rx_buf_wr = cv[6];
    assign rx_buf_full = cv[6] | cv[8];

    // Small frame window keeps the error-rate test short
    ifm_monitor #(.FBER_WINDOW(100), .FBER_LIMIT(1)) ifm_monitor_inst (.*);
    ifm_partner ifm_partner_inst (.quiet(quiet), .lvl(lvl), .pins(pins));

    // ************
    // Checking and bus tasks
    // ************
    task automatic close_out;
        $display("comparisons %0d, mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    function automatic logic [14:0] b(input int i);
        return 15'h1 << i;
    endfunction
    task automatic st(input int n, input logic [14:0] e);
        repeat (n) @(posedge core_clk);
        @(negedge core_clk);
        chk(32'(fault_status), 32'(e));
        chk(32'(switchover_req), 32'(|(e & ifm_pkg::FAULT_MASK)));
        chk(32'(alarm_active), 32'(|(e & ifm_pkg::ALARM_MASK)));
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d,
            input logic [1:0] er = ifm_pkg::RESP_OKAY);
        logic ta, tw, tb;
        logic [1:0] r;
        @(posedge core_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        tb = 1'b0;
        while (!tb) begin
            @(negedge core_clk);
            ta = s_axi_awvalid & s_axi_awready;
            tw = s_axi_wvalid & s_axi_wready;
            tb = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge core_clk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
        end
        s_axi_bready <= 1'b0;
        chk(32'(r), 32'(er));
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] ed,
            input logic [1:0] er = ifm_pkg::RESP_OKAY);
        logic ta, tr;
        logic [31:0] d;
        logic [1:0] r;
        @(posedge core_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        tr = 1'b0;
        while (!tr) begin
            @(negedge core_clk);
            ta = s_axi_arvalid & s_axi_arready;
            tr = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge core_clk);
            if (ta) s_axi_arvalid <= 1'b0;
        end
        s_axi_rready <= 1'b0;
        chk(d, ed);
        chk(32'(r), 32'(er));
    endtask

    // ************
    // Scenarios
    // ************
    task automatic t_regs;
        rd(ifm_pkg::ADDR_CTRL, ifm_pkg::CTRL_RESET);
        rd(ifm_pkg::ADDR_DATA_LIMIT, 32'h0000_04E2);
        rd(ifm_pkg::ADDR_CLK_LIMIT, 32'h0000_007D);
        wr(ifm_pkg::ADDR_DATA_LIMIT, 32'h0000_0008);
        wr(ifm_pkg::ADDR_CLK_LIMIT, 32'hFFFF_0008);
        rd(ifm_pkg::ADDR_CLK_LIMIT, 32'h0000_0008);
        wr(ifm_pkg::ADDR_STATUS, 32'hFFFF_FFFF);
        rd(ifm_pkg::ADDR_STATUS, 32'h0000_0000);
        wr(4'h2, 32'h0000_0001, ifm_pkg::RESP_SLVERR);
        rd(4'h2, 32'h0000_0000, ifm_pkg::RESP_SLVERR);
    endtask
    task automatic t_pins;
        for (int i = 0; i < 9; i++) begin
            @(posedge core_clk);
            cv <= 9'h1 << i;
            st(4, idx[i] < 0 ? 15'h0 : b(idx[i]));
            @(posedge core_clk);
            cv <= 9'h0;
            st(4, 15'h0);
        end
        wr(ifm_pkg::ADDR_CTRL, 32'h0000_0013);
        st(2, b(ifm_pkg::ST_TX_PROG));
        @(posedge core_clk);
        cv <= 9'h8;
        st(4, b(ifm_pkg::ST_TX_PROG) | b(ifm_pkg::ST_DROP));
        @(posedge core_clk);
        cv <= 9'h0;
        wr(ifm_pkg::ADDR_CTRL, 32'h0000_0000);
        st(4, 15'h0);
    endtask
    task automatic t_data;
        logic [14:0] e;
        for (int l = 0; l < 2; l++) begin
            for (int m = 0; m < 3; m++) begin
                wr(ifm_pkg::ADDR_CTRL, 32'(m * 5));
                @(posedge core_clk);
                quiet <= 4'h5;
                lvl <= l[0] ? 4'hF : 4'h0;
                e = 15'h0;
                if (m == 1) e = b(ifm_pkg::ST_TX_DATA) | b(ifm_pkg::ST_RX_DATA);
                if (m == 2 && l == 1) e = b(ifm_pkg::ST_TX_AIS) | b(ifm_pkg::ST_RX_AIS);
                st(30, e);
                chk(32'(tx_data_stuck_indication), 32'(|e[1:0]));
                chk(32'(rx_data_stuck_indication), 32'(|e[10:9]));
                @(posedge core_clk);
                quiet <= 4'h0;
                st(10, 15'h0);
            end
        end
    endtask
    task automatic t_clk;
        @(posedge core_clk);
        quiet <= 4'hA;
        st(30, b(ifm_pkg::ST_TX_CLK) | b(ifm_pkg::ST_RX_CLK));
        chk(32'({tx_use_internal_clk, rx_use_satellite_clk, rx_clock_inactive_fault}), 32'h7);
        @(posedge core_clk);
        quiet <= 4'h0;
        st(10, 15'h0);
        chk(32'({tx_use_internal_clk, rx_use_satellite_clk, rx_clock_inactive_fault}), 32'h0);
    endtask
    task automatic frame(input int nerr, input logic [14:0] e);
        for (int i = 0; i < 100; i++) begin
            @(posedge core_clk);
            frame_bit_valid <= 1'b1;
            frame_bit_err <= (i < nerr);
        end
        @(posedge core_clk);
        frame_bit_valid <= 1'b0;
        frame_bit_err <= 1'b0;
        st(3, e);
        chk(32'(frame_error_rate_fault), 32'(|e));
    endtask

    // ************
    // Clock, reset, sequence, watchdog
    // ************
    initial begin
        forever #4 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 5000) begin
            err_count++;
            close_out;
        end
    end
    initial begin
        repeat (20) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge core_clk);
        t_regs;
        t_pins;
        t_data;
        t_clk;
        frame(1, 15'h0);
        frame(2, b(ifm_pkg::ST_FBER));
        frame(0, 15'h0);
        close_out;
    end
endmodule
